// ===== rtl/tdf_top.sv
`timescale 1ns/10ps
// How it works
// R1: six-bit threshold; zero disables near-empty, else byte count.
// R2: near-empty event when bytes left drop below threshold.
// R3: near-empty level high while filled bytes below threshold.
// R4: sending threshold byte raises level and fires the event.
// R5: processor refills above threshold to clear and re-arm.
// R6: after the event, 65 minus threshold writes fit.
// R7: software should pick a small threshold, five to ten.
// R8: an end-of-message write tags the last written byte unless no byte waits.
// R9: processor writes end-of-message after each message or buffer.
// R10: end-of-message value is dropped and reads as zero.
// R11: several tagged messages may queue and go out in order.
// R12: circular mode moves on only after the end byte.
// R13: bytes leave least significant bit first.
// R14: eight bits per byte, six in six-bit packing.
// R15: HDLC busy status high between flags, low otherwise.
// R16: busy status always high in other modes.
// R17: empty flag is one when no data waits.
// R18: full flag set at 64 filled bytes.
// R19: data writes while full are dropped.
// R20: in HDLC, a message that runs dry before its end tag ends with an abort; other modes send idle fill.
// R21: after reset the FIFO is empty and idle.
module tdf_top
    import tdf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slot_bit_en,
    output logic tx_link_bit,
    output logic near_empty_irq,
    output logic message_done_irq,
    output logic near_empty_level,
    output logic fifo_empty_flag,
    output logic fifo_full_flag,
    output logic message_in_progress
);

    typedef struct packed {
        logic [DEPTH_N-1:0][8:0] mem;
        logic [6:0] wr;
        logic [6:0] rd;
        logic [6:0] start;
        logic [5:0] thr;
        tdf_mode_type mode;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic full;
        logic empty;
        logic near;
        logic near_irq;
        logic done_irq;
    } tdf_fifo_regs_type;

    localparam tdf_fifo_regs_type FIFO_RST = '{
        mem: '0, wr: PTR_RST, rd: PTR_RST, start: PTR_RST,
        thr: THRESH_RST, mode: MODE_HDLC, rdata: 32'h0000_0000,
        ready: 1'b0, slverr: 1'b0, full: 1'b0, empty: 1'b1,
        near: 1'b0, near_irq: 1'b0, done_irq: 1'b0};

    tdf_fifo_regs_type q;
    tdf_fifo_regs_type d;
    tdf_seq_if sq ();

    logic setup;
    logic acc_wr;
    logic [6:0] fill;
    logic [6:0] rd_next;
    logic [5:0] last_idx;
    logic head_eom;

    assign setup = psel && !penable;
    assign acc_wr = psel && penable && q.ready && pwrite;
    assign last_idx = q.wr[5:0] - 6'h01;

    // ======================================================
    // Register bus, FIFO pointers and status
    always_comb begin
        d = q;
        fill = 7'h00;
        rd_next = q.rd + PTR_ONE;
        head_eom = q.mem[q.rd[5:0]][8];
        d.ready = setup;
        d.slverr = 1'b0;
        d.done_irq = sq.msg_done;
        if (setup) begin
            d.rdata = 32'h0000_0000;
            case (paddr)
                ADDR_THRESH: d.rdata = {26'h0, q.thr};
                ADDR_STAT: begin
                    d.rdata[STAT_FULL_BIT] = q.full;
                    d.rdata[STAT_NEAR_BIT] = q.near;
                    d.rdata[STAT_EMPTY_BIT] = q.empty;
                    d.rdata[STAT_MSG_BIT] = sq.in_progress;
                end
                ADDR_MODE: d.rdata = {30'h0, q.mode};
                // R10: write-only locations read as zero
                ADDR_EOM, ADDR_DATA: d.rdata = 32'h0000_0000;
                default: d.slverr = 1'b1;
            endcase
        end
        if (acc_wr) begin
            case (paddr)
                // R1: threshold field
                ADDR_THRESH: d.thr = pwdata[5:0];
                ADDR_MODE: d.mode = tdf_mode_type'(pwdata[1:0]);
                ADDR_DATA: begin
                    // R19: full FIFO drops the byte
                    if (!q.full) begin
                        d.mem[q.wr[5:0]] = {1'b0, pwdata[7:0]};
                        d.wr = q.wr + PTR_ONE;
                    end
                end
                ADDR_EOM: begin
                    // R8: value ignored, tag last written byte
                    if (q.wr != q.start) begin
                        d.mem[last_idx][8] = 1'b1;
                    end
                end
                default: d.mode = q.mode;
            endcase
        end
        if (sq.byte_take) begin
            if (q.mode == MODE_CIRC) begin
                // R12: leave a buffer only when a newer one waits
                if (head_eom && rd_next != q.wr) begin
                    d.rd = rd_next;
                    d.start = rd_next;
                end else if (head_eom) begin
                    d.rd = q.start;
                end else begin
                    d.rd = rd_next;
                end
            end else begin
                d.rd = rd_next;
                d.start = rd_next;
            end
        end
        fill = d.wr - d.start;
        // R18: full at 64 filled bytes
        // R6: 65 minus threshold bytes fit once near-empty
        d.full = (fill == FIFO_DEPTH);
        // R17: empty when nothing waits to be sent
        d.empty = (d.wr == d.rd);
        // R3: level follows fill against threshold
        // R5: refilling past threshold clears and re-arms
        d.near = (d.thr != THRESH_RST) && (fill < {1'b0, d.thr});
        // R2: event only on a rise caused by transmission
        // R4: rise after sending the threshold byte
        d.near_irq = d.near && !q.near && sq.byte_take;
    end

    // R21: reset leaves the FIFO empty and idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= FIFO_RST;
        end else begin
            q <= d;
        end
    end

    // ======================================================
    // Sequencer link
    assign sq.byte_data = q.mem[q.rd[5:0]][7:0];
    assign sq.byte_eom = head_eom;
    assign sq.byte_valid = (q.wr != q.rd);
    assign sq.mode = q.mode;
    assign sq.slot_bit_en = slot_bit_en;

    tdf_sequencer u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .sq(sq)
    );

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
    assign tx_link_bit = sq.tx_bit;
    assign near_empty_irq = q.near_irq;
    assign message_done_irq = q.done_irq;
    assign near_empty_level = q.near;
    assign fifo_empty_flag = q.empty;
    assign fifo_full_flag = q.full;
    assign message_in_progress = sq.in_progress;

    // ======================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_data_write;
        acc_wr && paddr == ADDR_DATA;
    endsequence

    sequence s_eom_write;
        acc_wr && paddr == ADDR_EOM && q.wr != q.start;
    endsequence

    AST_FULL_DROP: assert property ( // R19
        s_data_write and q.full |=> q.wr == $past(q.wr))
        else $error("write while full changed the FIFO");
    AST_WRITE_TAKEN: assert property ( // R18
        s_data_write and !q.full |=> q.wr == $past(q.wr) + PTR_ONE)
        else $error("write below full was lost");
    AST_FULL_LEVEL: assert property ( // R18
        q.full == ((q.wr - q.start) == FIFO_DEPTH))
        else $error("full flag disagrees with fill");
    AST_NEAR_LEVEL: assert property ( // R3
        q.thr != THRESH_RST && (q.wr - q.start) < {1'b0, q.thr}
            |-> q.near)
        else $error("near-empty level low below threshold");
    AST_NEAR_OFF: assert property ( // R1
        q.thr == THRESH_RST |-> !q.near && !q.near_irq)
        else $error("near-empty active with zero threshold");
    AST_NEAR_EVENT: assert property ( // R4
        q.near_irq |-> q.near && $past(!q.near) && $past(sq.byte_take))
        else $error("near-empty event without a transmit rise");
    AST_EOM_TAG: assert property ( // R8
        s_eom_write |=> q.mem[$past(last_idx)][8])
        else $error("end-of-message write did not tag");
    AST_EOM_READ_ZERO: assert property ( // R10
        setup && !pwrite && paddr == ADDR_EOM |=> q.rdata == 32'h0
            && q.ready)
        else $error("end-of-message location read nonzero");
    AST_EMPTY_LEVEL: assert property ( // R17
        q.empty == (q.wr == q.rd))
        else $error("empty flag disagrees with pointers");
    AST_CIRC_REWIND: assert property ( // R12
        sq.byte_take && q.mode == MODE_CIRC && head_eom
            && rd_next == q.wr |=> q.rd == $past(q.start))
        else $error("circular buffer left without a successor");
    AST_APB_ONE_WAIT: assert property (
        setup |=> q.ready ##1 !q.ready)
        else $error("bus answer not on first access cycle");

endmodule

// ===== rtl/tdf_pkg.sv
package tdf_pkg;

    // ======================================================
    // Register indices and byte addresses (index times four)
    localparam logic [7:0] IDX_THRESH = 8'hB6;
    localparam logic [7:0] IDX_EOM = 8'hB7;
    localparam logic [7:0] IDX_DATA = 8'hB8;
    localparam logic [7:0] IDX_STAT = 8'hB9;
    localparam logic [7:0] IDX_MODE = 8'hBF;
    localparam logic [11:0] ADDR_THRESH = {2'h0, IDX_THRESH, 2'h0};
    localparam logic [11:0] ADDR_EOM = {2'h0, IDX_EOM, 2'h0};
    localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
    localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};

    // ======================================================
    // Status field positions
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_NEAR_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_MSG_BIT = 3;

    // ======================================================
    // FIFO geometry and reset values
    localparam int DEPTH_N = 64;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [6:0] PTR_ONE = 7'h01;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [5:0] THRESH_RST = 6'h00;

    // ======================================================
    // Serial characters and bits left after loading a character
    localparam logic [7:0] FLAG_CHAR = 8'h7E;
    localparam logic [7:0] ABORT_CHAR = 8'hFF;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam logic [2:0] BITS_LEFT8 = 3'h7;
    localparam logic [2:0] BITS_LEFT6 = 3'h5;
    localparam logic [2:0] BITS_NONE = 3'h0;

    typedef enum logic [1:0] {
        MODE_HDLC = 2'b00,
        MODE_CIRC = 2'b01,
        MODE_EIGHT_BIT_PACKING = 2'b10,
        MODE_SIX_BIT_PACKING = 2'b11
    } tdf_mode_type;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_DATA = 2'b01,
        SQ_ABORT = 2'b10
    } tdf_seq_state_type;

endpackage

// ===== rtl/tdf_seq_if.sv
`timescale 1ns/10ps
interface tdf_seq_if;
    import tdf_pkg::*;
    logic [7:0] byte_data;
    logic byte_eom;
    logic byte_valid;
    logic byte_take;
    tdf_mode_type mode;
    logic slot_bit_en;
    logic tx_bit;
    logic in_progress;
    logic msg_done;

    modport fifo_side(
        output byte_data, byte_eom, byte_valid, mode, slot_bit_en,
        input byte_take, tx_bit, in_progress, msg_done
    );
    modport seq_side(
        input byte_data, byte_eom, byte_valid, mode, slot_bit_en,
        output byte_take, tx_bit, in_progress, msg_done
    );
endinterface

// ===== rtl/tdf_sequencer.sv
`timescale 1ns/10ps
module tdf_sequencer
    import tdf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    tdf_seq_if.seq_side sq
);

    typedef struct packed {
        tdf_seq_state_type st;
        logic [7:0] sh;
        logic [2:0] left;
        logic bit_q;
        logic mip;
        logic done;
        logic last_eom;
    } tdf_seq_regs_type;

    localparam tdf_seq_regs_type SEQ_RST = '{
        st: SQ_IDLE, sh: 8'h00, left: BITS_NONE, bit_q: 1'b1,
        mip: 1'b0, done: 1'b0, last_eom: 1'b0};

    tdf_seq_regs_type q;
    tdf_seq_regs_type d;
    logic take;
    logic [7:0] load;
    logic [2:0] nbits;

    // ======================================================
    // Character sequencing
    always_comb begin
        d = q;
        d.done = 1'b0;
        take = 1'b0;
        load = IDLE_FILL;
        nbits = (sq.mode == MODE_SIX_BIT_PACKING) ? BITS_LEFT6 : BITS_LEFT8;
        if (sq.slot_bit_en) begin
            if (q.left == BITS_NONE) begin
                if (sq.mode == MODE_HDLC) begin
                    nbits = BITS_LEFT8;
                    unique case (q.st)
                        SQ_IDLE: begin
                            if (sq.byte_valid) begin
                                load = sq.byte_data;
                                take = 1'b1;
                                d.last_eom = sq.byte_eom;
                                d.st = SQ_DATA;
                            end else begin
                                load = FLAG_CHAR;
                            end
                        end
                        SQ_DATA: begin
                            // R11: close on tag, next message follows
                            if (q.last_eom) begin
                                load = FLAG_CHAR;
                                d.st = SQ_IDLE;
                                d.done = 1'b1;
                            end else if (sq.byte_valid) begin
                                load = sq.byte_data;
                                take = 1'b1;
                                d.last_eom = sq.byte_eom;
                            // R20: underrun mid-message
                            end else begin
                                load = ABORT_CHAR;
                                d.st = SQ_ABORT;
                            end
                        end
                        SQ_ABORT: begin
                            load = FLAG_CHAR;
                            d.st = SQ_IDLE;
                        end
                        default: begin
                            load = FLAG_CHAR;
                            d.st = SQ_IDLE;
                        end
                    endcase
                end else if (sq.byte_valid) begin
                    load = sq.byte_data;
                    take = 1'b1;
                    d.done = sq.byte_eom;
                end
                // R13: least significant bit leaves first
                d.bit_q = load[0];
                d.sh = {1'b0, load[7:1]};
                // R14: six or eight bits per byte
                d.left = nbits;
            end else begin
                d.bit_q = q.sh[0];
                d.sh = {1'b0, q.sh[7:1]};
                d.left = q.left - 3'h1;
            end
        end
        // R15: busy only between flags in HDLC
        // R16: always busy in other modes
        d.mip = (sq.mode != MODE_HDLC) || (d.st == SQ_DATA);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= SEQ_RST;
        end else begin
            q <= d;
        end
    end

    assign sq.byte_take = take;
    assign sq.tx_bit = q.bit_q;
    assign sq.in_progress = q.mip;
    assign sq.msg_done = q.done;

    // ======================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_underrun;
        sq.mode == MODE_HDLC && q.st == SQ_DATA && q.left == BITS_NONE
            && sq.slot_bit_en && !sq.byte_valid && !q.last_eom;
    endsequence

    AST_ABORT_ON_UNDERRUN: assert property ( // R20
        s_underrun |=> q.st == SQ_ABORT && q.bit_q && q.left == BITS_LEFT8)
        else $error("underrun did not start an abort");
    AST_LSB_FIRST: assert property ( // R13
        take |=> q.bit_q == $past(sq.byte_data[0]))
        else $error("first bit out is not the byte lsb");
    AST_SIX_BIT_PACKING_LEN: assert property ( // R14
        take && sq.mode == MODE_SIX_BIT_PACKING |=> q.left == BITS_LEFT6)
        else $error("six-bit packing sent wrong bit count");
    AST_MIP_NONHDLC: assert property ( // R16
        sq.mode != MODE_HDLC |=> q.mip)
        else $error("message in progress low outside HDLC");
    AST_MIP_HDLC: assert property ( // R15
        sq.mode == MODE_HDLC |=> q.mip == (q.st == SQ_DATA))
        else $error("message in progress wrong in HDLC");

endmodule

// ===== bench/tdf_link_model.sv
`timescale 1ns/10ps
module tdf_link_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic tx_link_bit,
    output logic slot_bit_en
);
    bit bit_q[$];
    logic pend_q;
    initial begin
        slot_bit_en = 1'b0;
        pend_q = 1'b0;
    end
    // ==========================================================
    // Slot pulse every other cycle, bit captured one cycle later
    always @(posedge pclk) begin
        if (pend_q === 1'b1) begin
            bit_q.push_back(tx_link_bit);
        end
        pend_q <= slot_bit_en;
        slot_bit_en <= run && !slot_bit_en;
    end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import tdf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, run, stop_on_near;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic pready, pslverr, err_v, slot_bit_en, tx_link_bit;
    logic near_empty_irq, message_done_irq, near_empty_level;
    logic fifo_empty_flag, fifo_full_flag, message_in_progress;
    int fails, samples_checked, near_cnt, done_cnt, p1, p2;
    bit pat[$];

    tdf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slot_bit_en(slot_bit_en),
        .tx_link_bit(tx_link_bit), .near_empty_irq(near_empty_irq),
        .message_done_irq(message_done_irq),
        .near_empty_level(near_empty_level),
        .fifo_empty_flag(fifo_empty_flag),
        .fifo_full_flag(fifo_full_flag),
        .message_in_progress(message_in_progress));
    tdf_link_model link (.pclk(pclk), .run(run),
        .tx_link_bit(tx_link_bit), .slot_bit_en(slot_bit_en));

    // ==========================================================
    // Clock, event counters and link stop
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (near_empty_irq === 1'b1) begin
            near_cnt++;
            if (stop_on_near) run <= 1'b0;
        end
        if (message_done_irq === 1'b1) done_cnt++;
    end

    // ==========================================================
    // Bus access and comparison
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fails++;
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_until_empty();
        int n;
        n = 0;
        while (fifo_empty_flag !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (fifo_empty_flag !== 1'b1) fails++;
        repeat (60) @(posedge pclk);
    endtask
    function automatic void put(logic [7:0] v, int nb);
        for (int i = 0; i < nb; i++) pat.push_back(v[i]);
    endfunction
    function automatic int find();
        int ok;
        for (int s = 0; s + pat.size() <= link.bit_q.size(); s++) begin
            ok = 1;
            foreach (pat[i]) if (link.bit_q[s + i] != pat[i]) ok = 0;
            if (ok == 1) return s;
        end
        return -1;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        final_report();
    end

    // ==========================================================
    // Test sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, run, stop_on_near} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_STAT, 32'h0);
        check("reset status", rd_v, 32'h0000_0004);
        // Idle flags first, so the first message has an opening flag
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        run <= 1'b0;
        apb(1'b1, ADDR_THRESH, 32'h0000_00FF);
        apb(1'b0, ADDR_THRESH, 32'h0);
        check("threshold", rd_v, 32'h0000_003F);
        apb(1'b1, ADDR_THRESH, 32'h0000_0004);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("near when empty", rd_v[3:0], 4'h6);
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped err", {rd_v[30:0], err_v}, 32'h0000_0001);
        for (int i = 0; i < 64; i++) apb(1'b1, ADDR_DATA, i);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("full", rd_v[2:0], 3'h1);
        apb(1'b1, ADDR_DATA, 32'h0000_00EE);
        apb(1'b0, ADDR_DATA, 32'h0);
        check("data reads", rd_v, 32'h0);
        stop_on_near <= 1'b1;
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("busy", rd_v[3:2], 2'h2);
        for (int n = 0; n < 3000 && run === 1'b1; n++) @(posedge pclk);
        check("near events", near_cnt, 1);
        check("near level", near_empty_level, 1'b1);
        stop_on_near <= 1'b0;
        for (int i = 0; i < 60; i++) apb(1'b1, ADDR_DATA, 8'h40 + i);
        @(posedge pclk);
        check("full after burst", fifo_full_flag, 1'b0);
        check("near cleared", near_empty_level, 1'b0);
        apb(1'b1, ADDR_DATA, 32'h0000_007C);
        @(posedge pclk);
        check("full again", fifo_full_flag, 1'b1);
        run <= 1'b1;
        wait_until_empty();
        put(FLAG_CHAR, 8);
        for (int i = 0; i < 64; i++) put(i, 8);
        for (int i = 0; i < 61; i++) put(8'h40 + i, 8);
        put(ABORT_CHAR, 8);
        put(FLAG_CHAR, 8);
        check("overflow stream", find() >= 0, 1'b1);
        check("near events 2", near_cnt, 2);
        apb(1'b0, ADDR_STAT, 32'h0);
        check("idle status", rd_v[3:0], 4'h6);
        // Keep the captured history so the flag before the pause stays whole
        run <= 1'b0;
        apb(1'b1, ADDR_DATA, 32'h0000_005A);
        apb(1'b1, ADDR_DATA, 32'h0000_003C);
        apb(1'b1, ADDR_EOM, 32'h0000_0055);
        apb(1'b1, ADDR_DATA, 32'h0000_00C3);
        apb(1'b1, ADDR_EOM, 32'h0000_00AA);
        apb(1'b0, ADDR_EOM, 32'h0);
        check("eom reads", rd_v, 32'h0);
        run <= 1'b1;
        wait_until_empty();
        check("done events", done_cnt, 2);
        pat.delete();
        put(FLAG_CHAR, 8);
        put(8'h5A, 8);
        put(8'h3C, 8);
        put(FLAG_CHAR, 8);
        p1 = find();
        pat.delete();
        put(FLAG_CHAR, 8);
        put(8'hC3, 8);
        put(FLAG_CHAR, 8);
        p2 = find();
        check("message order", p1 >= 0 && p2 > p1, 1'b1);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, ADDR_MODE, m);
            apb(1'b0, ADDR_STAT, 32'h0);
            check("busy non hdlc", rd_v[3], 1'b1);
        end
        link.bit_q.delete();
        apb(1'b1, ADDR_DATA, 32'h0000_0085);
        apb(1'b1, ADDR_EOM, 32'h0);
        wait_until_empty();
        pat.delete();
        put(8'h85, 6);
        put(8'hFF, 4);
        check("six bit pack", find() >= 0, 1'b1);
        final_report();
    end
endmodule
